// ==== shared/bis_defines.svh ====
// Timing and trial constants for the burner ignition sequencer
`ifndef BIS_DEFINES_SVH
`define BIS_DEFINES_SVH
`define BIS_CLK_HZ 64'd200000000
`define BIS_PURGE_S 64'd35
`define BIS_PURGE_CYC (`BIS_PURGE_S * `BIS_CLK_HZ)
`define BIS_TRIAL_S 64'd10
`define BIS_TRIAL_CYC (`BIS_TRIAL_S * `BIS_CLK_HZ)
`define BIS_LOCK_SHORT_S 64'd300
`define BIS_LOCK_LONG_S 64'd3600
`define BIS_LOCK_SHORT_CYC (`BIS_LOCK_SHORT_S * `BIS_CLK_HZ)
`define BIS_LOCK_LONG_CYC (`BIS_LOCK_LONG_S * `BIS_CLK_HZ)
`define BIS_MAX_TRIALS 2'h3
`define BIS_TRIALS_W 2
`define BIS_CNT_W 40
`endif

// ==== shared/bis_pkg.sv ====
// Types for the burner ignition sequencer
package bis_pkg;
  typedef enum logic [2:0] {
    BIS_IDLE = 3'h0,
    BIS_PURGE = 3'h1,
    BIS_TRIAL = 3'h2,
    BIS_BURN = 3'h3,
    BIS_LOCKOUT = 3'h4
  } bis_state_e;
endpackage

// ==== logic/bis_sequencer.sv ====
// Burner ignition sequencer: purge, three trials, burn, timed lockout
`timescale 1ns/100ps
`include "bis_defines.svh"

// How it works
// [R1] At most three trials per demand; lockout if third trial gets no flame.
// [R2] Lockout lasts 5 minutes or 1 hour, chosen by build parameter.
// [R3] Lockout expiry self-resets and grants three fresh trials.
// [R4] Only a power cycle (reset) clears lockout early; controller does it.
// [R5] Flame loss while demanded restarts ignition, counted as a trial.
// [R6] Power loss drops gas; on return with demand, ignition reruns.
// [R7] Controller enables on demand; sequencer holds 30-40 s purge delay.
// [R8] Gas, spark and sensing energize only after purge and airflow proven.
// [R9] Spark stops in the cycle flame is seen; gas stays open.
// [R10] Controller keeps combustion blower running throughout the demand.
// [R11] No configuration inputs; all delays and counts fixed at build.
// [R12] Open rollout limit closes the gas valve immediately in any state.
// [R13] Controller removes ignition enable at high limit; the blower keeps following want_heat and is not forced on.
// [R14] Lockout holds gas and spark off and ignores flame.
// [R15] Demand removal outside lockout closes gas, stops spark, idles, clears trial count.
module bis_sequencer #(
  parameter bit LONG_LOCKOUT = 1'b0,
  parameter logic [39:0] PURGE_CYC = 40'(`BIS_PURGE_CYC),
  parameter logic [39:0] TRIAL_CYC = 40'(`BIS_TRIAL_CYC),
  parameter logic [39:0] LOCK_SHORT_CYC = 40'(`BIS_LOCK_SHORT_CYC),
  parameter logic [39:0] LOCK_LONG_CYC = 40'(`BIS_LOCK_LONG_CYC)
)
(
  input wire logic ref_clk, // R11
  input wire logic resetn,
  input wire logic heat_demand,
  input wire logic airflow_prove,
  input wire logic rollout_ok,
  input wire logic flame_present,
  output logic gas_valve,
  output logic spark,
  output logic flame_sense,
  output logic lockout
);

  localparam logic [39:0] LOCK_CYC = LONG_LOCKOUT ? LOCK_LONG_CYC : LOCK_SHORT_CYC; // R2

  bis_pkg::bis_state_e state;
  bis_pkg::bis_state_e next_state;
  logic [`BIS_CNT_W-1:0] timer;
  logic [`BIS_TRIALS_W-1:0] trials;
  logic timer_done;
  logic trial_start;

  always_comb
  begin
    unique case (state)
      bis_pkg::BIS_PURGE: timer_done = (timer >= PURGE_CYC - 40'h1);
      bis_pkg::BIS_TRIAL: timer_done = (timer >= TRIAL_CYC - 40'h1);
      bis_pkg::BIS_LOCKOUT: timer_done = (timer >= LOCK_CYC - 40'h1);
      default: timer_done = 1'b0;
    endcase
  end

  // Sequence control
  always_comb
  begin
    next_state = state;
    trial_start = 1'b0;
    unique case (state)
      bis_pkg::BIS_IDLE:
        if (heat_demand)
          next_state = bis_pkg::BIS_PURGE; // R7
      bis_pkg::BIS_PURGE:
        if (!heat_demand)
          next_state = bis_pkg::BIS_IDLE; // R15
        else if (timer_done && airflow_prove && rollout_ok)
        begin
          next_state = bis_pkg::BIS_TRIAL; // R8
          trial_start = 1'b1;
        end
      bis_pkg::BIS_TRIAL:
        if (!heat_demand)
          next_state = bis_pkg::BIS_IDLE; // R15
        else if (flame_present && airflow_prove && rollout_ok)
          next_state = bis_pkg::BIS_BURN;
        else if (timer_done || !airflow_prove || !rollout_ok)
        begin
          if (trials >= `BIS_MAX_TRIALS)
            next_state = bis_pkg::BIS_LOCKOUT; // R1
          else
            next_state = bis_pkg::BIS_PURGE;
        end
      bis_pkg::BIS_BURN:
        if (!heat_demand)
          next_state = bis_pkg::BIS_IDLE; // R15
        else if (!flame_present || !airflow_prove || !rollout_ok)
        begin
          if (trials >= `BIS_MAX_TRIALS)
            next_state = bis_pkg::BIS_LOCKOUT; // R1
          else if (airflow_prove && rollout_ok)
          begin
            next_state = bis_pkg::BIS_TRIAL; // R5
            trial_start = 1'b1;
          end
          else
            next_state = bis_pkg::BIS_PURGE;
        end
      bis_pkg::BIS_LOCKOUT:
        if (timer_done)
          next_state = bis_pkg::BIS_IDLE; // R3
      default:
        next_state = bis_pkg::BIS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      state <= bis_pkg::BIS_IDLE; // R4 R6
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn || next_state != state)
      timer <= '0;
    else if (!timer_done)
      timer <= timer + 40'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn || next_state == bis_pkg::BIS_IDLE)
      trials <= '0; // R3 R15
    else if (trial_start)
      trials <= trials + 2'h1; // R5
  end

  // Outputs registered from the next state; flame and rollout act in the same edge
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      gas_valve <= 1'b0; // R6
      spark <= 1'b0;
      flame_sense <= 1'b0;
      lockout <= 1'b0;
    end
    else
    begin
      gas_valve <= (next_state == bis_pkg::BIS_TRIAL || next_state == bis_pkg::BIS_BURN)
        && rollout_ok; // R12 R14
      spark <= next_state == bis_pkg::BIS_TRIAL && !flame_present; // R9
      flame_sense <= next_state == bis_pkg::BIS_TRIAL || next_state == bis_pkg::BIS_BURN;
      lockout <= next_state == bis_pkg::BIS_LOCKOUT;
    end
  end

  chk_rollout_gas: assert property (@(posedge ref_clk) disable iff (!resetn)
    !rollout_ok |=> !gas_valve) else $error("gas open after rollout"); // R12
  chk_lock_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    lockout |-> !gas_valve && !spark) else $error("output active in lockout"); // R14
  chk_demand_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
    !heat_demand && state != bis_pkg::BIS_LOCKOUT |=> !gas_valve && !spark)
    else $error("output after demand drop"); // R15
  chk_flame_spark: assert property (@(posedge ref_clk) disable iff (!resetn)
    flame_present |=> !spark) else $error("spark while flame"); // R9
  chk_purge_first: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(gas_valve) |-> $past(state) != bis_pkg::BIS_IDLE)
    else $error("gas without purge"); // R8
  chk_trial_limit: assert property (@(posedge ref_clk) disable iff (!resetn)
    trials <= `BIS_MAX_TRIALS) else $error("trial count over limit"); // R1
  chk_lock_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(lockout) |-> $past(trials) == `BIS_MAX_TRIALS)
    else $error("lockout before third trial"); // R1
  chk_lock_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(lockout) |-> trials == 2'h0) else $error("trials not renewed"); // R3
  chk_airflow_gas: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(gas_valve) |-> $past(airflow_prove)) else $error("gas without airflow"); // R8

  // Outputs, state transitions and the trial count must follow the sequence rules
  chk_spark_gas: assert property (@(posedge ref_clk) disable iff (!resetn)
    spark |-> gas_valve && flame_sense)
    else $error("spark without gas"); // R8
  chk_sense_gas: assert property (@(posedge ref_clk) disable iff (!resetn)
    gas_valve |-> flame_sense)
    else $error("gas without sensing"); // R8
  chk_sense_trial: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_TRIAL |-> flame_sense)
    else $error("no sensing in trial"); // R8
  chk_airflow_loss: assert property (@(posedge ref_clk) disable iff (!resetn)
    gas_valve && !airflow_prove |=> !gas_valve)
    else $error("gas kept after airflow loss"); // R8
  chk_purge_enter: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_IDLE && heat_demand |=> state == bis_pkg::BIS_PURGE && !gas_valve)
    else $error("demand did not start purge"); // R7
  chk_purge_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_PURGE && !timer_done |=> !gas_valve && !spark)
    else $error("gas before purge end"); // R7
  chk_flame_burn: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_TRIAL && heat_demand && flame_present && airflow_prove && rollout_ok
    |=> gas_valve && !spark) else $error("flame did not stop spark"); // R9
  chk_restart_spark: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_BURN && heat_demand && !flame_present && airflow_prove && rollout_ok
    && trials < `BIS_MAX_TRIALS |=> spark && gas_valve) else $error("no restart"); // R5
  chk_trial_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    trial_start && heat_demand |=> trials == $past(trials) + 2'h1)
    else $error("trial not counted"); // R5
  chk_lock_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_LOCKOUT && !timer_done |=> lockout && !gas_valve)
    else $error("lockout left early"); // R14
  chk_lock_demand: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_LOCKOUT && !heat_demand && !timer_done |=> lockout)
    else $error("demand drop cleared lockout"); // R14
  chk_lock_expire: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_LOCKOUT && timer_done |=> !lockout && state == bis_pkg::BIS_IDLE)
    else $error("lockout did not expire"); // R3
  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == bis_pkg::BIS_IDLE |-> !gas_valve && !spark && !flame_sense && !lockout)
    else $error("output active in idle"); // R15
  chk_demand_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    !heat_demand && state != bis_pkg::BIS_LOCKOUT |=> trials == 2'h0)
    else $error("trial count kept"); // R15

endmodule

// ==== verification/bis_controller_model.sv ====
// Main unit controller model: heat demand and combustion blower
`timescale 1ns/100ps
module bis_controller_model (
  input wire logic want_heat,
  input wire logic blower_ok,
  input wire logic limit_ok,
  output logic heat_demand,
  output logic airflow_prove
);
  // An open high limit removes the ignition enable at once
  assign heat_demand = want_heat & limit_ok;
  // Blower runs for the whole demand; blower_ok models a slow prove switch
  assign airflow_prove = want_heat & blower_ok;
endmodule

// ==== verification/burner_ignition_sequencer_bench.sv ====
// Self-checking bench for the burner ignition sequencer
`timescale 1ns/100ps
module burner_ignition_sequencer_bench;
  localparam int LOCK = 50;
  logic ref_clk, resetn, want_heat, blower_ok, rollout_ok, flame_present;
  logic heat_demand, airflow_prove, gas_valve, spark, flame_sense, lockout;
  logic limit_ok, lockout_long;
  int fails, checks_done, n, trials;
  bis_controller_model i_ctl (.want_heat(want_heat), .blower_ok(blower_ok), .limit_ok(limit_ok),
    .heat_demand(heat_demand), .airflow_prove(airflow_prove));
  bis_sequencer #(.PURGE_CYC(40'h14), .TRIAL_CYC(40'hA), .LOCK_SHORT_CYC(40'h32),
    .LOCK_LONG_CYC(40'h64)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .heat_demand(heat_demand), .airflow_prove(airflow_prove), .rollout_ok(rollout_ok),
    .flame_present(flame_present), .gas_valve(gas_valve), .spark(spark),
    .flame_sense(flame_sense), .lockout(lockout));
  bis_sequencer #(.LONG_LOCKOUT(1'b1), .PURGE_CYC(40'h14), .TRIAL_CYC(40'hA),
    .LOCK_SHORT_CYC(40'h32), .LOCK_LONG_CYC(40'h64)) i_dut_long (.ref_clk(ref_clk),
    .resetn(resetn), .heat_demand(heat_demand), .airflow_prove(airflow_prove),
    .rollout_ok(rollout_ok), .flame_present(flame_present), .gas_valve(), .spark(),
    .flame_sense(), .lockout(lockout_long));
  always @(posedge gas_valve) trials++;
  task check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  // Waits at falling edges until gas (sel 0) or lockout (sel 1) reaches val
  task wait_out(input int sel, input logic val, input int lim);
    n = 0;
    while ((sel ? lockout : gas_valve) !== val && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task t_ignite;
    want_heat = 1'b1;
    wait_out(0, 1'b1, 40);
    check(gas_valve, 1'b0);
    blower_ok = 1'b1;
    wait_out(0, 1'b1, 10);
    check(n < 10, 1'b1);
    check(spark & flame_sense, 1'b1);
    flame_present = 1'b1;
    @(negedge ref_clk);
    check(spark, 1'b0);
    check(gas_valve, 1'b1);
    $display("ignite done");
  endtask
  task t_faults;
    flame_present = 1'b0;
    @(negedge ref_clk);
    check(spark & gas_valve, 1'b1);
    flame_present = 1'b1;
    rollout_ok = 1'b0;
    @(negedge ref_clk);
    check(gas_valve, 1'b0);
    rollout_ok = 1'b1;
    want_heat = 1'b0;
    @(negedge ref_clk);
    check(gas_valve | spark | flame_sense, 1'b0);
    $display("faults done");
  endtask
  task t_lockout;
    flame_present = 1'b0;
    trials = 0;
    want_heat = 1'b1;
    wait_out(0, 1'b1, 30);
    check(n >= 20, 1'b1);
    wait_out(1, 1'b1, 200);
    check(lockout, 1'b1);
    check(trials == 3, 1'b1);
    flame_present = 1'b1;
    @(negedge ref_clk);
    check(gas_valve | spark, 1'b0);
    flame_present = 1'b0;
    wait_out(1, 1'b0, LOCK + 5);
    check(n >= LOCK - 3 && n < LOCK + 5, 1'b1);
    check(lockout_long, 1'b1);
    trials = 0;
    wait_out(1, 1'b1, 200);
    check(trials == 3, 1'b1);
    check(lockout_long, 1'b0);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(lockout | gas_valve, 1'b0);
    resetn = 1'b1;
    wait_out(0, 1'b1, 40);
    check(gas_valve, 1'b1);
    limit_ok = 1'b0;
    @(negedge ref_clk);
    check(gas_valve | spark | flame_sense, 1'b0);
    limit_ok = 1'b1;
    $display("lockout done");
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    finish_test;
  end
  initial
  begin
    {resetn, want_heat, blower_ok, flame_present} = 4'h0;
    rollout_ok = 1'b1;
    limit_ok = 1'b1;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    t_ignite;
    t_faults;
    t_lockout;
    finish_test;
  end
endmodule
